// [verification/mem_partner.sv]
/*
  program and data memory model for the execution block.
  assumes zero-latency reads and a data write at the edge ending Q4.
*/
`timescale 1ns/1ps
module mem_partner
  import bit_branch_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic [PC_W-1:0]    prog_addr,
  output logic      [INSTR_W-1:0] prog_data,
  input  wire dmem_req_type       dmem_req,
  output logic      [DATA_W-1:0]  dmem_rdata
);
  // ==========
  // memories
  logic [INSTR_W-1:0] pmem [256];
  logic [DATA_W-1:0]  dmem [4096];
  initial for (int k = 0; k < 256; k++) pmem[k] = 16'h0000;
  assign prog_data  = pmem[prog_addr[8:1]];
  assign dmem_rdata = dmem[dmem_req.addr];
  always @(posedge clk_sys) begin
    if (dmem_req.we) begin
      dmem[dmem_req.addr] <= dmem_req.wdata;
    end
  end
endmodule

// [verification/tb_top.sv]
/*
  random and corner instructions run through the block, checked at its ports.
  assumes the memory partner model on the far side.
*/
`timescale 1ns/1ps
module tb_top
  import bit_branch_pkg::*;
;
  logic                  clk_sys = 1'h0;
  logic                  resetn = 1'h0;
  logic                  avs_read = 1'h0;
  logic                  avs_write = 1'h0;
  logic [AVS_ADDR_W-1:0] avs_address = 5'h00;
  logic [BUS_W-1:0]      avs_writedata = 32'h0;
  logic [BUS_W-1:0]      avs_readdata;
  logic                  avs_waitrequest;
  logic [PC_W-1:0]       prog_addr;
  logic [INSTR_W-1:0]    prog_data;
  logic [DATA_W-1:0]     dmem_rdata;
  dmem_req_type          dmem_req;
  phase_type             q_phase;
  int                    errors = 0;
  int                    checks_done = 0;
  logic [31:0]           seed = 32'h2D02;
  logic [7:0]            brop [4] = '{OPC_BRANCH_CARRY_SET, OPC_BRANCH_CARRY_CLR,
                                      OPC_BRANCH_NEG_SET, OPC_BRANCH_NEG_CLR};

  always #20 clk_sys = ~clk_sys;

  logic_bit_branch_exec i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .prog_addr(prog_addr), .prog_data(prog_data), .dmem_req(dmem_req),
    .dmem_rdata(dmem_rdata), .q_phase(q_phase));

  mem_partner i_mem (
    .clk_sys(clk_sys), .prog_addr(prog_addr), .prog_data(prog_data),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));

  // ==========
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [11:0] ea(logic [7:0] f, logic a, logic [3:0] bk,
                                     logic [11:0] ix, logic x);
    if (a) return {bk, f};
    if (x && f <= 8'h5F) return ix + {4'h0, f};
    return {(f >= 8'h60) ? 4'hF : 4'h0, f};
  endfunction

  task automatic finish_test();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    @(posedge clk_sys);
    avs_address   <= ad;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'h0 && k < 50);
    rd = avs_readdata;
    @(posedge clk_sys);
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
    if (k >= 50) begin errors++; finish_test(); end
  endtask

  task automatic wait_ph(input phase_type p);
    int k;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (q_phase !== p && k < 20);
    if (k >= 20) begin errors++; finish_test(); end
  endtask

  // ==========
  // main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] ins;
    logic [7:0]  f, n, acc, opnd, res;
    logic [11:0] ad, idx;
    logic [20:0] tgt;
    logic [3:0]  bank;
    logic [2:0]  kind, b, st;
    logic        a, d, x, tk, wr;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'h1;
    for (int k = 0; k < 8; k++) begin
      bus(1'h0, 5'(k * 4), 32'h0, r);
      chk(r, 32'h0);
    end
    for (int it = 0; it < 40; it++) begin
      r = rnd();
      {opnd, acc, n, f} = r;
      r = rnd();
      kind = r[2:0] % 6;
      {idx, x, bank, st, b, d, a} = r[27:3];
      if (it < 2) begin
        kind = 3'(2 + it);
        n = it[0] ? 8'h80 : 8'h7F;
      end
      ad  = ea(f, a, bank, idx, x);
      ins = kind == 0 ? {OPC_AND_FILE, d, a, f} :
            kind == 1 ? {OPC_FILE_BIT_CLEAR, b, a, f} : {brop[kind[1:0] ^ 2'h2], n};
      tk  = kind > 1 && ((kind[2] ? st[2] : st[0]) ^ kind[0]);
      res = kind == 0 ? acc & opnd : opnd & ~(BIT_ONE << b);
      wr  = kind == 1 || (kind == 0 && d);
      tgt = 21'h2 + {{12{n[7]}}, n, 1'h0};
      i_mem.pmem[0] = ins;
      i_mem.dmem[ad] = opnd;
      bus(1'h1, REG_PC, 32'h0, r);
      bus(1'h1, REG_ACC, {24'h0, acc}, r);
      bus(1'h1, REG_STATUS, {29'h0, st}, r);
      bus(1'h1, REG_BANK, {28'h0, bank}, r);
      bus(1'h1, REG_INDEX, {20'h0, idx}, r);
      bus(1'h1, REG_CTRL, {30'h0, x, 1'h1}, r);
      wait_ph(PH_Q2);
      i_mem.pmem[0] = 16'h0000;
      repeat (2) @(negedge clk_sys);
      chk(q_phase, PH_Q4);
      chk(dmem_req.we, wr);
      if (wr) chk({dmem_req.addr, dmem_req.wdata}, {ad, res});
      @(negedge clk_sys);
      chk(prog_addr, tk ? tgt : 21'h2);
      @(negedge clk_sys);
      chk(prog_addr, tk ? tgt : 21'h4);
      repeat (4) @(negedge clk_sys);
      chk(prog_addr, tk ? 21'(tgt + 21'h2) : 21'h6);
      bus(1'h1, REG_ACC, {24'h0, ~acc}, r);
      bus(1'h0, REG_ACC, 32'h0, r);
      chk(r, (kind == 0 && !d) ? res : acc);
      bus(1'h0, REG_STATUS, 32'h0, r);
      chk(r, kind == 0 ? {res[7], res == 8'h00, st[0]} : st);
      bus(1'h1, REG_CTRL, 32'h0, r);
      wait_ph(PH_Q1);
      if (wr) chk(i_mem.dmem[ad], res);
    end
    finish_test();
  end
endmodule

// [verilog/bit_branch_pkg.sv]
/*
  Shared constants and types for the logic, bit-clear and conditional branch
  execution block: opcode patterns, instruction field positions, addressing
  constants, register map, reset values and the instruction phase encoding.
  Assumes one clock and a 16-bit instruction word from program memory.
*/
package bit_branch_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W    = 8;
  localparam int INSTR_W   = 16;
  localparam int DADDR_W   = 12;
  localparam int BSEL_W    = 4;
  localparam int PC_W      = 21;
  localparam int AVS_ADDR_W = 5;
  localparam int BUS_W     = 32;
  localparam int BYTE_W    = 8;
  localparam int BUS_BYTES = 4;

  // ==========================================================================
  // instruction fields
  localparam int I_MSB     = 15;
  localparam int OPC4_LSB  = 12;
  localparam int OPC6_LSB  = 10;
  localparam int OPC8_LSB  = 8;
  localparam int B_MSB     = 11;
  localparam int B_LSB     = 9;
  localparam int D_BIT     = 9;
  localparam int A_BIT     = 8;
  localparam int F_MSB     = 7;
  localparam int BR_OFF_W  = 9;
  localparam int PC_STEP   = 2;

  // ==========================================================================
  // opcode patterns
  localparam logic [5:0] OPC_AND_FILE          = 6'h05;
  localparam logic [3:0] OPC_FILE_BIT_CLEAR    = 4'h9;
  localparam logic [7:0] OPC_BRANCH_CARRY_SET  = 8'hE2;
  localparam logic [7:0] OPC_BRANCH_CARRY_CLR  = 8'hE3;
  localparam logic [7:0] OPC_BRANCH_NEG_SET    = 8'hE6;
  localparam logic [7:0] OPC_BRANCH_NEG_CLR    = 8'hE7;

  // ==========================================================================
  // operand addressing
  localparam logic [7:0] ILO_MAX        = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0] ACCESS_LO_PAGE = 4'h0;
  localparam logic [3:0] ACCESS_HI_PAGE = 4'hF;
  localparam logic [7:0] BIT_ONE        = 8'h01;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_ACC    = 5'h08;
  localparam logic [4:0] REG_BANK   = 5'h0C;
  localparam logic [4:0] REG_PC     = 5'h10;
  localparam logic [4:0] REG_INDEX  = 5'h14;
  localparam logic [4:0] REG_INSTR  = 5'h18;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int ST_C_BIT     = 0;
  localparam int ST_Z_BIT     = 1;
  localparam int ST_N_BIT     = 2;

  // ==========================================================================
  // types and reset values
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_type;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
  } flags_type;

  typedef struct packed {
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0]  wdata;
    logic               we;
  } dmem_req_type;

  localparam flags_type    FLAGS_RST = 3'h0;
  localparam dmem_req_type DMEM_RST  = 21'h000000;
  localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
  localparam logic [BSEL_W-1:0]  BANK_RST  = 4'h0;
  localparam logic [DADDR_W-1:0] INDEX_RST = 12'h000;
  localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;

endpackage

// [verilog/logic_bit_branch_exec.sv]
/*
  Execution block for AND of accumulator with file, file bit clear and the
  four carry/negative conditional relative branches, on a four-phase
  instruction cycle (one phase per clk_sys), with an Avalon-MM register slave.
  Assumes program memory returns the word at prog_addr by the Q1 edge and
  data memory reads combinationally and writes on the edge that ends Q4.
*/
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps

// Behaviour
// [RULE1] AND of accumulator with file register updates only negative and zero flags.
// [RULE2] the result goes to the accumulator when d is 0 and back to the file when d is 1.
// [RULE3] access bit 0 selects the access bank, 1 lets the bank select register pick the bank.
// [RULE4] extended set, access bit 0 and f up to 5Fh address index base plus f.
// [RULE5] branch on carry set jumps only when carry is 1.
// [RULE6] a taken branch loads the incremented counter plus twice the signed offset.
// [RULE7] untaken branch takes one cycle, taken one writes the counter in Q4 then idles one cycle.
// [RULE8] file bit clear clears the chosen bit of the file and touches no flag.
// [RULE9] branch on negative set jumps only when negative is 1.
// [RULE10] branch on carry clear jumps only when carry is 0.
// [RULE11] branch on negative clear jumps only when negative is 0, same target math.
// [RULE12] AND and bit clear decode in Q1, read in Q2, process in Q3, write in Q4.
// [RULE13] conditional branches leave every flag unchanged.
module logic_bit_branch_exec
  import bit_branch_pkg::*;
#(
  parameter int PC_WIDTH = PC_W
) (
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  input  wire logic [AVS_ADDR_W-1:0]   avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [BUS_W-1:0]        avs_writedata,
  input  wire logic [BUS_BYTES-1:0]    avs_byteenable,
  output logic      [BUS_W-1:0]        avs_readdata,
  output logic                         avs_waitrequest,
  output logic      [PC_WIDTH-1:0]     prog_addr,
  input  wire logic [INSTR_W-1:0]      prog_data,
  output dmem_req_type                 dmem_req,
  input  wire logic [DATA_W-1:0]       dmem_rdata,
  output phase_type                    q_phase
);

  // ==========================================================================
  // decode functions
  function automatic logic is_and_file(input logic [INSTR_W-1:0] i);
    return i[I_MSB:OPC6_LSB] == OPC_AND_FILE;
  endfunction

  function automatic logic is_bit_clear(input logic [INSTR_W-1:0] i);
    return i[I_MSB:OPC4_LSB] == OPC_FILE_BIT_CLEAR;
  endfunction

  function automatic logic is_cond_branch(input logic [INSTR_W-1:0] i);
    logic [7:0] op;
    op = i[I_MSB:OPC8_LSB];
    return (op == OPC_BRANCH_CARRY_SET) || (op == OPC_BRANCH_CARRY_CLR) ||
           (op == OPC_BRANCH_NEG_SET) || (op == OPC_BRANCH_NEG_CLR);
  endfunction

  function automatic logic branch_taken(input logic [7:0] op, input flags_type fl);
    logic t;
    t = 1'b0;
    case (op)
      OPC_BRANCH_CARRY_SET: t = fl.c;   // RULE5
      OPC_BRANCH_CARRY_CLR: t = !fl.c;  // RULE10
      OPC_BRANCH_NEG_SET:   t = fl.n;   // RULE9
      OPC_BRANCH_NEG_CLR:   t = !fl.n;  // RULE11
      default:              t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic [DADDR_W-1:0] operand_addr(
    input logic [INSTR_W-1:0] i,
    input logic [BSEL_W-1:0]  bank,
    input logic [DADDR_W-1:0] idx,
    input logic               ext
  );
    logic [7:0] f;
    f = i[F_MSB:0];
    if (i[A_BIT]) begin
      return {bank, f};                              // RULE3
    end else if (ext && (f <= ILO_MAX)) begin
      return idx + DADDR_W'(f);                      // RULE4
    end else if (f >= ACCESS_SPLIT) begin
      return {ACCESS_HI_PAGE, f};                    // RULE3
    end else begin
      return {ACCESS_LO_PAGE, f};
    end
  endfunction

  function automatic logic [BUS_W-1:0] be_merge(
    input logic [BUS_W-1:0]     old_w,
    input logic [BUS_W-1:0]     new_w,
    input logic [BUS_BYTES-1:0] be
  );
    logic [BUS_W-1:0] r;
    r = old_w;
    for (int k = 0; k < BUS_BYTES; k++) begin
      if (be[k]) begin
        r[k*BYTE_W +: BYTE_W] = new_w[k*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // state
  phase_type           phase_reg;
  phase_type           phase_next;
  logic [INSTR_W-1:0]  ir_reg;
  logic                exec_reg;
  logic                flush_reg;
  logic [PC_WIDTH-1:0] pc_reg;
  logic [DATA_W-1:0]   acc_reg;
  logic [DATA_W-1:0]   opnd_reg;
  logic [DATA_W-1:0]   result_reg;
  flags_type           flags_reg;
  logic [BSEL_W-1:0]   bank_select_reg;
  logic [DADDR_W-1:0]  index_reg;
  logic                ctrl_run_reg;
  logic                ctrl_ext_reg;
  dmem_req_type        dmem_req_reg;
  logic                wait_reg;
  logic [BUS_W-1:0]    rdata_reg;

  // ==========================================================================
  // datapath and decode
  wire logic                q1_go      = (phase_reg == PH_Q1) && ctrl_run_reg;
  wire logic                fetch_exec = q1_go && !flush_reg;
  wire logic                at_q3      = (phase_reg == PH_Q3);
  wire logic                at_q4      = (phase_reg == PH_Q4);
  wire logic [7:0]          cur_op     = ir_reg[I_MSB:OPC8_LSB];
  wire logic                op_and     = is_and_file(ir_reg);
  wire logic                op_clr     = is_bit_clear(ir_reg);
  wire logic                op_br      = is_cond_branch(ir_reg);
  wire logic                br_take    = branch_taken(cur_op, flags_reg);
  wire logic                jump       = at_q4 && exec_reg && op_br && br_take;
  wire logic [DATA_W-1:0]   and_result = acc_reg & opnd_reg;
  wire logic [DATA_W-1:0]   clr_mask   = BIT_ONE << ir_reg[B_MSB:B_LSB];
  wire logic [DATA_W-1:0]   clr_result = opnd_reg & ~clr_mask;
  wire logic [DATA_W-1:0]   alu_result = op_and ? and_result : clr_result;
  wire logic                file_write = exec_reg && ((op_and && ir_reg[D_BIT]) || op_clr);
  wire logic                acc_write  = exec_reg && op_and && !ir_reg[D_BIT];
  wire logic [PC_WIDTH-1:0] br_offset  = {{(PC_WIDTH-BR_OFF_W){ir_reg[F_MSB]}},
                                          ir_reg[F_MSB:0], 1'b0};
  wire logic [PC_WIDTH-1:0] br_target  = pc_reg + br_offset;
  wire logic [PC_WIDTH-1:0] pc_inc     = pc_reg + PC_WIDTH'(PC_STEP);
  wire logic [DADDR_W-1:0]  fetch_addr = operand_addr(prog_data, bank_select_reg,
                                                      index_reg, ctrl_ext_reg);

  // ==========================================================================
  // register bus decode
  wire logic               bus_req  = avs_read || avs_write;
  wire logic               sw_wr    = avs_write && !wait_reg;
  wire logic               sw_idle  = !ctrl_run_reg && (phase_reg == PH_Q1);
  wire logic               wr_core  = sw_wr && sw_idle;
  wire logic               wr_ctrl  = sw_wr && (avs_address == REG_CTRL);
  wire logic               wr_stat  = wr_core && (avs_address == REG_STATUS);
  wire logic               wr_acc   = wr_core && (avs_address == REG_ACC);
  wire logic               wr_bank  = wr_core && (avs_address == REG_BANK);
  wire logic               wr_pc    = wr_core && (avs_address == REG_PC);
  wire logic               wr_index = wr_core && (avs_address == REG_INDEX);
  wire logic [BUS_W-1:0]   ctrl_word = (BUS_W'(ctrl_run_reg) << CTRL_RUN_BIT) |
                                       (BUS_W'(ctrl_ext_reg) << CTRL_EXT_BIT);
  wire logic [BUS_W-1:0]   stat_word = (BUS_W'(flags_reg.c) << ST_C_BIT) |
                                       (BUS_W'(flags_reg.z) << ST_Z_BIT) |
                                       (BUS_W'(flags_reg.n) << ST_N_BIT);
  wire logic [BUS_W-1:0]   rd_mux =
    (avs_address == REG_CTRL)   ? ctrl_word :
    (avs_address == REG_STATUS) ? stat_word :
    (avs_address == REG_ACC)    ? BUS_W'(acc_reg) :
    (avs_address == REG_BANK)   ? BUS_W'(bank_select_reg) :
    (avs_address == REG_PC)     ? BUS_W'(pc_reg) :
    (avs_address == REG_INDEX)  ? BUS_W'(index_reg) :
    (avs_address == REG_INSTR)  ? BUS_W'(ir_reg) : 32'h0000_0000;
  wire logic [BUS_W-1:0]   wr_word = be_merge(rd_mux, avs_writedata, avs_byteenable);

  // ==========================================================================
  // phase sequencer
  always_comb begin
    case (phase_reg)
      PH_Q1:   phase_next = ctrl_run_reg ? PH_Q2 : PH_Q1;
      PH_Q2:   phase_next = PH_Q3;
      PH_Q3:   phase_next = PH_Q4;
      PH_Q4:   phase_next = PH_Q1;
      default: phase_next = PH_Q1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= PH_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ==========================================================================
  // fetch, decode and branch flush
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ir_reg    <= INSTR_RST;
      exec_reg  <= 1'b0;
      flush_reg <= 1'b0;
    end else if (q1_go) begin
      if (!flush_reg) begin
        ir_reg <= prog_data;                               // RULE12
      end
      exec_reg  <= fetch_exec;                             // RULE7
      flush_reg <= 1'b0;
    end else if (jump) begin
      flush_reg <= 1'b1;                                   // RULE7
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pc_reg <= '0;
    end else if (fetch_exec) begin
      pc_reg <= pc_inc;
    end else if (jump) begin
      pc_reg <= br_target;                                 // RULE6
    end else if (wr_pc) begin
      pc_reg <= wr_word[PC_WIDTH-1:0];
    end
  end

  // ==========================================================================
  // operand read, process and data memory write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      opnd_reg   <= ACC_RST;
      result_reg <= ACC_RST;
    end else begin
      if (phase_reg == PH_Q2) begin
        opnd_reg <= dmem_rdata;                            // RULE12
      end
      if (at_q3) begin
        result_reg <= alu_result;                          // RULE1
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dmem_req_reg <= DMEM_RST;
    end else if (fetch_exec) begin
      dmem_req_reg.addr <= fetch_addr;                     // RULE3
    end else if (at_q3) begin
      dmem_req_reg.we    <= file_write;                    // RULE2
      dmem_req_reg.wdata <= alu_result;                    // RULE8
    end else if (at_q4) begin
      dmem_req_reg.we <= 1'b0;
    end
  end

  // ==========================================================================
  // accumulator and flags
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= ACC_RST;
    end else if (at_q4 && acc_write) begin
      acc_reg <= result_reg;                               // RULE2
    end else if (wr_acc) begin
      acc_reg <= wr_word[DATA_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flags_reg <= FLAGS_RST;
    end else if (at_q4 && exec_reg && op_and) begin      // RULE13
      flags_reg.n <= result_reg[DATA_W-1];                 // RULE1
      flags_reg.z <= (result_reg == ACC_RST);              // RULE1
    end else if (wr_stat) begin
      flags_reg.n <= wr_word[ST_N_BIT];
      flags_reg.z <= wr_word[ST_Z_BIT];
      flags_reg.c <= wr_word[ST_C_BIT];
    end
  end

  // ==========================================================================
  // software registers and Avalon slave
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bank_select_reg <= BANK_RST;
      index_reg       <= INDEX_RST;
      ctrl_run_reg    <= 1'b0;
      ctrl_ext_reg    <= 1'b0;
    end else begin
      if (wr_bank) begin
        bank_select_reg <= wr_word[BSEL_W-1:0];
      end
      if (wr_index) begin
        index_reg <= wr_word[DADDR_W-1:0];
      end
      if (wr_ctrl) begin
        ctrl_run_reg <= wr_word[CTRL_RUN_BIT];
        ctrl_ext_reg <= wr_word[CTRL_EXT_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
      if (avs_read && wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign prog_addr       = pc_reg;
  assign dmem_req        = dmem_req_reg;
  assign q_phase         = phase_reg;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_exec_q3;
    at_q3 && exec_reg;
  endsequence
  sequence s_branch_q4;
    at_q4 && exec_reg && op_br;
  endsequence
  sequence s_idle_cycle;
    ($stable(pc_reg) && !dmem_req_reg.we && !exec_reg) [*4];
  endsequence

  property p_and_flags;
    s_exec_q3 ##0 op_and |-> ##2 (flags_reg.n == $past(and_result[DATA_W-1], 2)) &&
      (flags_reg.z == ($past(and_result, 2) == ACC_RST)) && $stable(flags_reg.c);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and flags wrong"); // RULE1

  property p_dest_file;
    s_exec_q3 ##0 op_and ##0 ir_reg[D_BIT] |=> dmem_req_reg.we &&
      (dmem_req_reg.wdata == $past(and_result)) ##1 $stable(acc_reg);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("and to file failed"); // RULE2

  property p_dest_acc;
    s_exec_q3 ##0 op_and ##0 !ir_reg[D_BIT] |=> !dmem_req_reg.we
      ##1 (acc_reg == $past(result_reg));
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("and to acc failed"); // RULE2

  property p_bank_addr;
    (phase_reg == PH_Q2) && exec_reg && (op_and || op_clr) && ir_reg[A_BIT] |->
      dmem_req_reg.addr == {bank_select_reg, ir_reg[F_MSB:0]};
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("bank address wrong"); // RULE3

  property p_index_addr;
    (phase_reg == PH_Q2) && exec_reg && (op_and || op_clr) && !ir_reg[A_BIT] &&
      ctrl_ext_reg && (ir_reg[F_MSB:0] <= ILO_MAX) |->
      dmem_req_reg.addr == index_reg + DADDR_W'(ir_reg[F_MSB:0]);
  endproperty
  a_index_addr: assert property (p_index_addr) else $error("indexed address wrong"); // RULE4

  property p_carry_set;
    s_branch_q4 ##0 (cur_op == OPC_BRANCH_CARRY_SET) |=> flush_reg == $past(flags_reg.c);
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry set branch wrong"); // RULE5

  property p_neg_set;
    s_branch_q4 ##0 (cur_op == OPC_BRANCH_NEG_SET) |=> flush_reg == $past(flags_reg.n);
  endproperty
  a_neg_set: assert property (p_neg_set) else $error("neg set branch wrong"); // RULE9

  property p_carry_clr;
    s_branch_q4 ##0 (cur_op == OPC_BRANCH_CARRY_CLR) |=> flush_reg != $past(flags_reg.c);
  endproperty
  a_carry_clr: assert property (p_carry_clr) else $error("carry clr branch wrong"); // RULE10

  property p_neg_clr;
    s_branch_q4 ##0 (cur_op == OPC_BRANCH_NEG_CLR) |=> flush_reg != $past(flags_reg.n);
  endproperty
  a_neg_clr: assert property (p_neg_clr) else $error("neg clr branch wrong"); // RULE11

  property p_target;
    s_branch_q4 ##0 br_take |=> pc_reg == $past(pc_reg) + $past(br_offset);
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong"); // RULE6

  property p_taken_idle;
    s_branch_q4 ##0 br_take ##1 ctrl_run_reg |-> ##1 s_idle_cycle;
  endproperty
  a_taken_idle: assert property (p_taken_idle) else $error("no idle after jump"); // RULE7

  property p_untaken;
    s_branch_q4 ##0 !br_take |=> !flush_reg && $stable(pc_reg);
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken branch moved pc"); // RULE7

  property p_clear_bit;
    s_exec_q3 ##0 op_clr |=> dmem_req_reg.we && (dmem_req_reg.wdata ==
      ($past(opnd_reg) & ~$past(clr_mask))) ##1 $stable(flags_reg);
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("bit clear wrong"); // RULE8

  property p_file_phases;
    fetch_exec && (is_bit_clear(prog_data) ||
      (is_and_file(prog_data) && prog_data[D_BIT])) |=>
      (!dmem_req_reg.we) [*2] ##1 (dmem_req_reg.we && at_q4) ##1 !dmem_req_reg.we;
  endproperty
  a_file_phases: assert property (p_file_phases) else $error("file op phases wrong"); // RULE12

  property p_branch_flags;
    s_branch_q4 |=> $stable(flags_reg);
  endproperty
  a_branch_flags: assert property (p_branch_flags) else $error("branch changed flags"); // RULE13

endmodule
